// [hw/rfa_pkg.sv]
package rfa_pkg;
	// Register byte offsets inside the register page
	localparam logic [11:0] OFS_RX_CFG   = 12'h102;
	localparam logic [11:0] OFS_RX_CTL   = 12'h104;
	localparam logic [11:0] OFS_TX_CFG   = 12'h106;
	localparam logic [11:0] OFS_TX_CMD   = 12'h108;
	localparam logic [11:0] OFS_BUF_CFG  = 12'h10a;
	localparam logic [11:0] OFS_LINE_CTL = 12'h112;
	localparam logic [11:0] OFS_SELF_CTL = 12'h114;
	localparam logic [11:0] OFS_BUS_CTL  = 12'h116;
	localparam logic [11:0] OFS_TEST_CTL = 12'h118;
	localparam logic [11:0] OFS_ISQ      = 12'h120;
	localparam logic [11:0] OFS_RX_EVT   = 12'h124;
	localparam logic [11:0] OFS_TX_EVT   = 12'h128;
	localparam logic [11:0] OFS_BUF_EVT  = 12'h12c;
	localparam logic [11:0] OFS_MISS_CNT = 12'h130;
	localparam logic [11:0] OFS_COL_CNT  = 12'h132;
	localparam logic [11:0] OFS_LINE_ST  = 12'h134;
	localparam logic [11:0] OFS_SELF_ST  = 12'h136;
	localparam logic [11:0] OFS_BUS_ST   = 12'h138;
	localparam logic [11:0] OFS_TDR_CNT  = 12'h13c;

	// Register numbers that read back in bits 5:0
	localparam logic [5:0] ID_RX_CFG   = 6'h03;
	localparam logic [5:0] ID_RX_CTL   = 6'h05;
	localparam logic [5:0] ID_TX_CFG   = 6'h07;
	localparam logic [5:0] ID_TX_CMD   = 6'h09;
	localparam logic [5:0] ID_BUF_CFG  = 6'h0b;
	localparam logic [5:0] ID_LINE_CTL = 6'h13;
	localparam logic [5:0] ID_SELF_CTL = 6'h15;
	localparam logic [5:0] ID_BUS_CTL  = 6'h17;
	localparam logic [5:0] ID_TEST_CTL = 6'h19;
	localparam logic [5:0] ID_RX_EVT   = 6'h04;
	localparam logic [5:0] ID_TX_EVT   = 6'h08;
	localparam logic [5:0] ID_BUF_EVT  = 6'h0c;
	localparam logic [5:0] ID_LINE_ST  = 6'h14;
	localparam logic [5:0] ID_SELF_ST  = 6'h16;
	localparam logic [5:0] ID_BUS_ST   = 6'h18;

	// Upper ten bits of every stored register reset to zero
	localparam logic [9:0]  FIELD_RESET = 10'h000;
	localparam logic [15:0] ISQ_RESET   = 16'h0000;
	localparam int          CNT_W       = 10;
	localparam int          NUM_CNT     = 3;

	// Field positions within the upper ten bits (bit 6 of the word is index 0)
	localparam int ACT_ONCE_BIT   = 0;
	localparam int CFG_GOOD_IE    = 2;
	localparam int CFG_DMA_ONLY   = 3;
	localparam int CFG_CRC_IE     = 6;
	localparam int CFG_RUNT_IE    = 7;
	localparam int CFG_EXTRA_IE   = 8;
	localparam int CTL_HASH_KEEP  = 0;
	localparam int CTL_ANY_KEEP   = 1;
	localparam int CTL_GOOD_KEEP  = 2;
	localparam int CTL_GROUP_KEEP = 3;
	localparam int CTL_OWN_KEEP   = 4;
	localparam int CTL_BCAST_KEEP = 5;
	localparam int CTL_CRC_KEEP   = 6;
	localparam int CTL_RUNT_KEEP  = 7;
	localparam int CTL_EXTRA_KEEP = 8;
	localparam int EVT_IAHASH     = 0;
	localparam int EVT_DRIBBLE    = 1;
	localparam int EVT_GOOD       = 2;
	localparam int EVT_HASHED     = 3;
	localparam int EVT_OWN        = 4;
	localparam int EVT_BCAST      = 5;
	localparam int EVT_CRC        = 6;
	localparam int EVT_RUNT       = 7;
	localparam int EVT_EXTRA      = 8;

	// Frame length limits in bytes
	localparam logic [10:0] RUNT_LIMIT  = 11'd64;
	localparam logic [10:0] MAX_LEN     = 11'd1518;
	localparam logic [10:0] DISCARD_LEN = 11'd8;
endpackage : rfa_pkg

// [hw/rfa_clear_count.sv]
`timescale 1ns/1ps
module rfa_clear_count
	import rfa_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             inc_i,
	input  wire logic             clear_i,
	output logic [CNT_W-1:0]      count_o
);
	logic [CNT_W-1:0] next_count;

	// Count wraps; a count arriving with the read clear is kept as one
	always_comb begin
		next_count = count_o;
		if (clear_i) begin
			next_count = inc_i ? CNT_W'(1) : '0;
		end else if (inc_i) begin
			next_count = count_o + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			count_o <= '0;
		end else begin
			count_o <= next_count;
		end
	end
endmodule : rfa_clear_count

// [hw/rfa_regs.sv]
//Behaviour
//- Receive control holds nine keep bits, one per received frame class.
//- A frame counts as accepted only when it is actually stored.
//- Four keep bits and their interrupt enables act fully independently.
//- Enabled interrupt without keep bit: interrupt fires, frame dropped, length zero.
//- Five keep bits filter on own, group, all-ones, any and hash address.
//- Hashed plus good frame: upper event bits report the hash index.
//- Event bits set on every event, whatever the enables say.
//- Any frame event with its enable set raises a host interrupt, except a good frame while DMA-only is set.
//- Reading an event register clears it to zero, unless a new event arrives in the same cycle.
//- Frames shorter than sixty-four bytes count as runts.
`timescale 1ns/1ps
module rfa_regs
	import rfa_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [11:0] host_addr_i,
	input  wire logic        host_rd_i,
	input  wire logic        host_wr_i,
	input  wire logic [15:0] host_wdata_i,
	output logic [15:0]      host_rdata_o,
	input  wire logic        frame_done_i,
	input  wire logic [10:0] frame_len_i,
	input  wire logic        frame_crc_bad_i,
	input  wire logic        frame_dribble_i,
	input  wire logic        dest_own_i,
	input  wire logic        dest_group_i,
	input  wire logic        dest_bcast_i,
	input  wire logic        dest_hash_i,
	input  wire logic [5:0]  hash_index_i,
	input  wire logic [9:0]  tx_event_set_i,
	input  wire logic [9:0]  buf_event_set_i,
	input  wire logic [2:0]  count_inc_i,
	input  wire logic [9:0]  tx_command_i,
	input  wire logic [9:0]  line_status_i,
	input  wire logic [9:0]  self_status_i,
	input  wire logic [9:0]  bus_status_i,
	output logic             frame_store_o,
	output logic [10:0]      frame_store_len_o,
	output logic             irq_o,
	output logic [3:0]       act_once_o,
	output logic [9:0]       receive_config_o,
	output logic [9:0]       receive_control_o,
	output logic [9:0]       transmit_config_o,
	output logic [9:0]       buffer_config_o,
	output logic [9:0]       line_control_o,
	output logic [9:0]       self_control_o,
	output logic [9:0]       bus_control_o,
	output logic [9:0]       test_control_o
);
	////////////////////////////////////////////////////////////////////////
	logic [9:0]       rx_evt;
	logic [9:0]       tx_evt;
	logic [9:0]       buf_evt;
	logic [9:0]       next_rx_evt;
	logic [9:0]       next_tx_evt;
	logic [9:0]       next_buf_evt;
	logic [9:0]       next_rx_cfg;
	logic [9:0]       next_rx_ctl;
	logic [9:0]       next_tx_cfg;
	logic [9:0]       next_buf_cfg;
	logic [9:0]       next_line_ctl;
	logic [9:0]       next_self_ctl;
	logic [9:0]       next_bus_ctl;
	logic [9:0]       next_test_ctl;
	logic [3:0]       next_act_once;
	logic [15:0]      next_rdata;
	logic             next_store;
	logic [10:0]      next_store_len;
	logic             next_irq;
	logic [CNT_W-1:0] cnt [NUM_CNT];
	logic [2:0]       cnt_clear;
	logic             is_runt;
	logic             is_extra;
	logic             is_good;
	logic             addr_pass;
	logic             class_pass;
	logic [9:0]       frame_evt;
	logic             rd_hit;
	logic             wr_hit;

	assign rd_hit = host_rd_i;
	assign wr_hit = host_wr_i;

	////////////////////////////////////////////////////////////////////////
	// Frame classification and keep decision
	always_comb begin
		is_runt    = frame_len_i < RUNT_LIMIT;
		is_extra   = frame_len_i > MAX_LEN;
		is_good    = !frame_crc_bad_i && !is_runt && !is_extra;
		// Destination filter; any-address keep overrides the rest
		addr_pass  = receive_control_o[CTL_ANY_KEEP]
			|| (dest_own_i && receive_control_o[CTL_OWN_KEEP])
			|| (dest_group_i && receive_control_o[CTL_GROUP_KEEP])
			|| (dest_bcast_i && receive_control_o[CTL_BCAST_KEEP])
			|| (dest_hash_i && receive_control_o[CTL_HASH_KEEP]);
		// Every failing class needs its own keep bit, irq enables not consulted
		class_pass = (!is_extra || receive_control_o[CTL_EXTRA_KEEP])
			&& (!is_runt || receive_control_o[CTL_RUNT_KEEP])
			&& (!frame_crc_bad_i || receive_control_o[CTL_CRC_KEEP])
			&& (!is_good || receive_control_o[CTL_GOOD_KEEP]);
		// Very short frames are never stored
		next_store     = frame_done_i && addr_pass && class_pass
			&& (frame_len_i >= DISCARD_LEN);
		next_store_len = next_store ? frame_len_i : 11'h000;
		frame_evt = '0;
		frame_evt[EVT_DRIBBLE] = frame_dribble_i;
		frame_evt[EVT_GOOD]    = is_good;
		frame_evt[EVT_HASHED]  = dest_hash_i;
		frame_evt[EVT_IAHASH]  = dest_hash_i && receive_control_o[CTL_HASH_KEEP];
		if (is_good && dest_hash_i) begin
			frame_evt[9:4] = hash_index_i;
		end else begin
			frame_evt[EVT_OWN]   = is_good && dest_own_i && receive_control_o[CTL_OWN_KEEP];
			frame_evt[EVT_BCAST] = is_good && dest_bcast_i
				&& receive_control_o[CTL_BCAST_KEEP];
			frame_evt[EVT_CRC]   = frame_crc_bad_i;
			frame_evt[EVT_RUNT]  = is_runt;
			frame_evt[EVT_EXTRA] = is_extra;
		end
		// Interrupt follows the enable alone, even for a dropped frame
		// Good-frame interrupt is held off while every frame goes by DMA
		next_irq = frame_done_i && (
			(is_extra && receive_config_o[CFG_EXTRA_IE])
			|| (is_runt && receive_config_o[CFG_RUNT_IE])
			|| (frame_crc_bad_i && receive_config_o[CFG_CRC_IE])
			|| (is_good && receive_config_o[CFG_GOOD_IE]
				&& !receive_config_o[CFG_DMA_ONLY]));
	end

	////////////////////////////////////////////////////////////////////////
	// Event registers; a new event beats the read clear
	always_comb begin
		next_rx_evt  = rx_evt;
		next_tx_evt  = tx_evt;
		next_buf_evt = buf_evt;
		if (rd_hit && host_addr_i == OFS_RX_EVT) begin
			next_rx_evt = '0;
		end
		if (rd_hit && host_addr_i == OFS_TX_EVT) begin
			next_tx_evt = '0;
		end
		if (rd_hit && host_addr_i == OFS_BUF_EVT) begin
			next_buf_evt = '0;
		end
		// A hash-index frame replaces flags, as the two meanings cannot mix
		if (frame_done_i) begin
			next_rx_evt = (is_good && dest_hash_i) ? frame_evt
				: (next_rx_evt | frame_evt);
		end
		next_tx_evt  = next_tx_evt | tx_event_set_i;
		next_buf_evt = next_buf_evt | buf_event_set_i;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_evt  <= FIELD_RESET;
			tx_evt  <= FIELD_RESET;
			buf_evt <= FIELD_RESET;
		end else begin
			rx_evt  <= next_rx_evt;
			tx_evt  <= next_tx_evt;
			buf_evt <= next_buf_evt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clear-on-read counters: missed frames, collisions, reflectometer
	assign cnt_clear[0] = rd_hit && host_addr_i == OFS_MISS_CNT;
	assign cnt_clear[1] = rd_hit && host_addr_i == OFS_COL_CNT;
	assign cnt_clear[2] = rd_hit && host_addr_i == OFS_TDR_CNT;

	for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
		rfa_clear_count u_cnt (
			.clk_i   (clk_i),
			.reset_i (reset_i),
			.inc_i   (count_inc_i[g]),
			.clear_i (cnt_clear[g]),
			.count_o (cnt[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration writes; act-once bit is never stored, only pulsed
	always_comb begin
		next_rx_cfg   = receive_config_o;
		next_rx_ctl   = receive_control_o;
		next_tx_cfg   = transmit_config_o;
		next_buf_cfg  = buffer_config_o;
		next_line_ctl = line_control_o;
		next_self_ctl = self_control_o;
		next_bus_ctl  = bus_control_o;
		next_test_ctl = test_control_o;
		next_act_once = 4'h0;
		if (wr_hit) begin
			case (host_addr_i)
				OFS_RX_CFG: begin
					next_rx_cfg   = host_wdata_i[15:6] & ~10'h001;
					next_act_once[0] = host_wdata_i[6];
				end
				OFS_RX_CTL:   next_rx_ctl   = host_wdata_i[15:6];
				OFS_TX_CFG:   next_tx_cfg   = host_wdata_i[15:6];
				OFS_BUF_CFG: begin
					next_buf_cfg  = host_wdata_i[15:6] & ~10'h001;
					next_act_once[3] = host_wdata_i[6];
				end
				OFS_LINE_CTL: next_line_ctl = host_wdata_i[15:6];
				OFS_SELF_CTL: begin
					next_self_ctl = host_wdata_i[15:6] & ~10'h001;
					next_act_once[1] = host_wdata_i[6];
				end
				OFS_BUS_CTL: begin
					next_bus_ctl  = host_wdata_i[15:6] & ~10'h001;
					next_act_once[2] = host_wdata_i[6];
				end
				OFS_TEST_CTL: next_test_ctl = host_wdata_i[15:6];
				default:      next_act_once = 4'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; reserved and status words never change state, event and counter reads clear them
	always_comb begin
		next_rdata = host_rdata_o;
		if (rd_hit) begin
			case (host_addr_i)
				OFS_RX_CFG:   next_rdata = {receive_config_o, ID_RX_CFG};
				OFS_RX_CTL:   next_rdata = {receive_control_o, ID_RX_CTL};
				OFS_TX_CFG:   next_rdata = {transmit_config_o, ID_TX_CFG};
				OFS_TX_CMD:   next_rdata = {tx_command_i, ID_TX_CMD};
				OFS_BUF_CFG:  next_rdata = {buffer_config_o, ID_BUF_CFG};
				OFS_LINE_CTL: next_rdata = {line_control_o, ID_LINE_CTL};
				OFS_SELF_CTL: next_rdata = {self_control_o, ID_SELF_CTL};
				OFS_BUS_CTL:  next_rdata = {bus_control_o, ID_BUS_CTL};
				OFS_TEST_CTL: next_rdata = {test_control_o, ID_TEST_CTL};
				OFS_ISQ:      next_rdata = ISQ_RESET;
				OFS_RX_EVT:   next_rdata = {rx_evt, ID_RX_EVT};
				OFS_TX_EVT:   next_rdata = {tx_evt, ID_TX_EVT};
				OFS_BUF_EVT:  next_rdata = {buf_evt, ID_BUF_EVT};
				OFS_MISS_CNT: next_rdata = {cnt[0], 6'h00};
				OFS_COL_CNT:  next_rdata = {cnt[1], 6'h00};
				OFS_LINE_ST:  next_rdata = {line_status_i, ID_LINE_ST};
				OFS_SELF_ST:  next_rdata = {self_status_i, ID_SELF_ST};
				OFS_BUS_ST:   next_rdata = {bus_status_i, ID_BUS_ST};
				OFS_TDR_CNT:  next_rdata = {cnt[2], 6'h00};
				default:      next_rdata = 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register stage for configuration, read data and frame results
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			receive_config_o  <= FIELD_RESET;
			receive_control_o <= FIELD_RESET;
			transmit_config_o <= FIELD_RESET;
			buffer_config_o   <= FIELD_RESET;
			line_control_o    <= FIELD_RESET;
			self_control_o    <= FIELD_RESET;
			bus_control_o     <= FIELD_RESET;
			test_control_o    <= FIELD_RESET;
			act_once_o        <= 4'h0;
			host_rdata_o      <= 16'h0000;
			frame_store_o     <= 1'b0;
			frame_store_len_o <= 11'h000;
			irq_o             <= 1'b0;
		end else begin
			receive_config_o  <= next_rx_cfg;
			receive_control_o <= next_rx_ctl;
			transmit_config_o <= next_tx_cfg;
			buffer_config_o   <= next_buf_cfg;
			line_control_o    <= next_line_ctl;
			self_control_o    <= next_self_ctl;
			bus_control_o     <= next_bus_ctl;
			test_control_o    <= next_test_ctl;
			act_once_o        <= next_act_once;
			host_rdata_o      <= next_rdata;
			frame_store_o     <= next_store;
			frame_store_len_o <= next_store_len;
			irq_o             <= next_irq;
		end
	end
endmodule : rfa_regs

// [dv/rfa_regs_checker.sv]
`timescale 1ns/1ps
module rfa_regs_checker
	import rfa_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [11:0] host_addr_i,
	input wire logic        host_rd_i,
	input wire logic        host_wr_i,
	input wire logic [15:0] host_rdata_o,
	input wire logic        frame_done_i,
	input wire logic [10:0] frame_len_i,
	input wire logic        frame_crc_bad_i,
	input wire logic        frame_store_o,
	input wire logic [10:0] frame_store_len_o,
	input wire logic        irq_o,
	input wire logic [9:0]  receive_config_o,
	input wire logic [9:0]  receive_control_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Event read with no frame racing it, since a new event wins
	wire evt_rd = host_rd_i && host_addr_i == OFS_RX_EVT && !frame_done_i;
	////////////////////////////////////////////////////////////////
	AST_STORE_CAUSE: assert property (frame_store_o |-> $past(frame_done_i))
		else $error("store pulse without a frame");
	AST_TINY_DROP: assert property (frame_done_i && frame_len_i < DISCARD_LEN
		|=> !frame_store_o)
		else $error("tiny frame stored");
	AST_DROP_ZERO: assert property (frame_done_i
		|=> frame_store_o || frame_store_len_o == 11'h0)
		else $error("dropped frame length not zero");
	AST_STORE_LEN: assert property (frame_done_i && frame_len_i <= MAX_LEN
		|=> !frame_store_o || frame_store_len_o == $past(frame_len_i))
		else $error("stored length wrong");
	AST_RUNT_KEEP: assert property (frame_done_i && frame_len_i < RUNT_LIMIT
		&& !receive_control_o[CTL_RUNT_KEEP] |=> !frame_store_o)
		else $error("short frame stored without keep");
	AST_CRC_IRQ: assert property (frame_done_i && frame_crc_bad_i
		&& receive_config_o[CFG_CRC_IE] |=> irq_o)
		else $error("bad check interrupt missing");
	AST_RUNT_IRQ: assert property (frame_done_i && frame_len_i < RUNT_LIMIT
		&& receive_config_o[CFG_RUNT_IE] |=> irq_o)
		else $error("short frame interrupt missing");
	AST_IRQ_CAUSE: assert property (irq_o
		|-> $past(frame_done_i) && $past(receive_config_o) != 10'h0)
		else $error("interrupt without enabled event");
	AST_CLEAR: assert property (evt_rd ##1 !frame_done_i ##1 evt_rd
		|=> host_rdata_o == {10'h0, ID_RX_EVT})
		else $error("event register not cleared by read");
	AST_CTL_READ: assert property (host_rd_i && !host_wr_i && host_addr_i == OFS_RX_CTL
		|=> host_rdata_o == {receive_control_o, ID_RX_CTL})
		else $error("keep bits read back wrong");
	AST_RSV_WR: assert property (host_wr_i && host_addr_i == 12'h10c
		|=> $stable(receive_control_o))
		else $error("reserved write changed state");
	// Main scenarios seen
	COV_STORE: cover property (frame_store_o);
	COV_IRQ_DROP: cover property (irq_o && !frame_store_o);
	COV_CLEAR: cover property (evt_rd ##2 evt_rd);
endmodule : rfa_regs_checker

// [dv/rfa_host_model.sv]
`timescale 1ns/1ps
module rfa_host_model (
	input  wire logic        clk_i,
	output logic [11:0]      addr_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic [15:0]      wdata_o,
	input  wire logic [15:0] rdata_i
);
	initial begin
		addr_o = 12'h0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 16'h0;
	end
	// One-cycle write strobe; bus shows junk once released
	task automatic put(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		addr_o <= ~a;
	endtask : put
	// Data is registered, so it lands just after the taking edge
	task automatic get(input logic [11:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask : get
endmodule : rfa_host_model

// [dv/rfa_regs_bench.sv]
`timescale 1ns/1ps
module rfa_regs_bench;
	import rfa_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [11:0] addr;
	logic rd, wr, store, irq;
	logic [15:0] wdata, rdata, r;
	logic done = 1'b0, crc = 1'b0, own = 1'b0, hsh = 1'b0;
	logic grp = 1'b0, bca = 1'b0, drb = 1'b0;
	logic [9:0] tev = 10'h0, bev = 10'h0;
	logic [3:0] once;
	logic [15:0] ctl_w;
	wire logic [9:0] cfgo [8];
	logic [10:0] len = 11'h0, slen;
	logic [5:0] idx = 6'h0;
	logic [2:0] inc = 3'h0;
	logic [9:0] rbk [4];
	logic [9:0] k, c;
	logic [31:0] seed = 32'hd08ced8f, r32;
	int err_total = 0, samples_checked = 0, cyc = 0;
	logic [11:0] regs [8] = '{OFS_RX_CFG, OFS_RX_CTL, OFS_TX_CFG, OFS_BUF_CFG,
		OFS_LINE_CTL, OFS_SELF_CTL, OFS_BUS_CTL, OFS_TEST_CTL};
	logic [5:0] ids [8] = '{ID_RX_CFG, ID_RX_CTL, ID_TX_CFG, ID_BUF_CFG,
		ID_LINE_CTL, ID_SELF_CTL, ID_BUS_CTL, ID_TEST_CTL};
	logic [11:0] sts [4] = '{OFS_TX_CMD, OFS_LINE_ST, OFS_SELF_ST, OFS_BUS_ST};
	logic [5:0] sid [4] = '{ID_TX_CMD, ID_LINE_ST, ID_SELF_ST, ID_BUS_ST};
	logic [11:0] cnt [3] = '{OFS_MISS_CNT, OFS_COL_CNT, OFS_TDR_CNT};
	logic [10:0] corner [6] = '{11'd7, 11'd8, 11'd63, 11'd64, 11'd1518, 11'd1519};
	////////////////////////////////////////////////////////////////
	rfa_host_model host (.clk_i(clk_i), .addr_o(addr), .rd_o(rd), .wr_o(wr),
		.wdata_o(wdata), .rdata_i(rdata));
	// Every input driven from the bench; status words fixed for the run
	rfa_regs uut (.clk_i(clk_i), .reset_i(reset_i), .host_addr_i(addr), .host_rd_i(rd),
		.host_wr_i(wr), .host_wdata_i(wdata), .host_rdata_o(rdata), .frame_done_i(done),
		.frame_len_i(len), .frame_crc_bad_i(crc), .frame_dribble_i(drb),
		.dest_own_i(own), .dest_group_i(grp), .dest_bcast_i(bca), .dest_hash_i(hsh),
		.hash_index_i(idx), .tx_event_set_i(tev), .buf_event_set_i(bev),
		.count_inc_i(inc), .tx_command_i(rbk[0]), .line_status_i(rbk[1]),
		.self_status_i(rbk[2]), .bus_status_i(rbk[3]), .frame_store_o(store),
		.frame_store_len_o(slen), .irq_o(irq), .act_once_o(once),
		.receive_config_o(cfgo[0]), .receive_control_o(cfgo[1]),
		.transmit_config_o(cfgo[2]), .buffer_config_o(cfgo[3]),
		.line_control_o(cfgo[4]), .self_control_o(cfgo[5]), .bus_control_o(cfgo[6]),
		.test_control_o(cfgo[7]));
	always #5 clk_i = ~clk_i;
	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : lfsr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	// Frame class decides keep and interrupt independently
	task automatic frame(input logic [10:0] n, input logic bad, input logic hit,
		input logic hh);
		logic rn, ex, ok, kp, fire, gp, bc, dr;
		logic [5:0] hx;
		logic [15:0] ev;
		rn = n < RUNT_LIMIT;
		ex = n > MAX_LEN;
		ok = !bad && !rn && !ex;
		hx = seed[20:15];
		gp = seed[22];
		bc = seed[23];
		dr = seed[24];
		kp = (k[CTL_ANY_KEEP] || hit && k[CTL_OWN_KEEP] || hh && k[CTL_HASH_KEEP]
			|| gp && k[CTL_GROUP_KEEP] || bc && k[CTL_BCAST_KEEP])
			&& (!bad || k[CTL_CRC_KEEP]) && (!rn || k[CTL_RUNT_KEEP])
			&& (!ex || k[CTL_EXTRA_KEEP]) && (!ok || k[CTL_GOOD_KEEP]) && n >= DISCARD_LEN;
		fire = bad && c[CFG_CRC_IE] || rn && c[CFG_RUNT_IE] || ex && c[CFG_EXTRA_IE]
			|| ok && c[CFG_GOOD_IE] && !c[CFG_DMA_ONLY];
		// Whole event word: hash index form, or one flag per frame property
		ev = (ok && hh) ? {hx, 2'b11, dr, k[CTL_HASH_KEEP], ID_RX_EVT}
			: {1'b0, ex, rn, bad, ok && bc && k[CTL_BCAST_KEEP], ok && hit && k[CTL_OWN_KEEP],
			hh, ok, dr, hh && k[CTL_HASH_KEEP], ID_RX_EVT};
		@(posedge clk_i);
		len <= n;
		crc <= bad;
		own <= hit;
		hsh <= hh;
		idx <= hx;
		grp <= gp;
		bca <= bc;
		drb <= dr;
		done <= 1'b1;
		@(posedge clk_i);
		done <= 1'b0;
		#1;
		chk({store, irq}, {kp, fire});
		if (!kp || !ex) chk({5'h0, slen}, kp ? n : 11'h0);
		host.get(OFS_RX_EVT, r);
		if (ok && hh) chk(r, ev);
		else chk(r, ev);
		host.get(OFS_RX_EVT, r);
		chk(r, {10'h0, ID_RX_EVT});
	endtask : frame
	// Hang guard, well above the expected run length
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		for (int i = 0; i < 4; i++) rbk[i] = 10'(lfsr());
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			r32 = lfsr();
			if (i == 1) ctl_w = r32[15:0];
			host.put(regs[i], r32[15:0]);
			#1 chk(once, {i == 3, i == 6, i == 5, i == 0} & {4{r32[6]}});
			host.get(regs[i], r);
			chk(r, {r32[15:7], r32[6] && !(i inside {0, 3, 5, 6}), ids[i]});
			chk(cfgo[i], {r32[15:7], r32[6] && !(i inside {0, 3, 5, 6})});
		end
		for (int i = 0; i < 4; i++) begin
			host.get(sts[i], r);
			chk(r, {rbk[i], sid[i]});
		end
		host.put(12'h10c, 16'hffff);
		host.get(12'h10c, r);
		chk(r, 16'h0);
		host.get(OFS_RX_CTL, r);
		chk(r, {ctl_w[15:6], ID_RX_CTL});
		$display("register test done");
		for (int i = 0; i < 48; i++) begin
			if (i % 8 == 0) begin
				r32 = lfsr();
				k = r32[9:0];
				c = {r32[19:11], 1'b0};
				host.put(OFS_RX_CTL, {k, 6'h0});
				host.put(OFS_RX_CFG, {c, 6'h0});
			end
			r32 = lfsr();
			frame(i < 6 ? corner[i] : {r32[14] & r32[10], r32[9:0]}, r32[11], r32[12], r32[13]);
		end
		k = 10'h002;
		c = 10'h040;
		host.put(OFS_RX_CTL, {k, 6'h0});
		host.put(OFS_RX_CFG, {c, 6'h0});
		frame(11'd100, 1'b1, 1'b0, 1'b0);
		k = 10'h005;
		host.put(OFS_RX_CTL, {k, 6'h0});
		frame(11'd200, 1'b0, 1'b0, 1'b1);
		$display("frame test done");
		for (int j = 0; j < 3; j++) begin
			r32 = lfsr();
			repeat (r32[4:0] + 1) begin
				@(posedge clk_i);
				inc <= 3'h1 << j;
			end
			@(posedge clk_i);
			inc <= 3'h0;
			host.get(cnt[j], r);
			chk(r, {{5'h0, r32[4:0]} + 10'h1, 6'h0});
			host.get(cnt[j], r);
			chk(r, 16'h0);
		end
		$display("counter test done");
		// One set pulse on each of the other two event words, then read clear
		r32 = lfsr();
		@(posedge clk_i);
		tev <= r32[9:0];
		bev <= r32[19:10];
		@(posedge clk_i);
		tev <= 10'h0;
		bev <= 10'h0;
		host.get(OFS_TX_EVT, r);
		chk(r, {r32[9:0], ID_TX_EVT});
		host.get(OFS_BUF_EVT, r);
		chk(r, {r32[19:10], ID_BUF_EVT});
		host.get(OFS_TX_EVT, r);
		chk(r, {10'h0, ID_TX_EVT});
		host.get(OFS_BUF_EVT, r);
		chk(r, {10'h0, ID_BUF_EVT});
		$display("event test done");
		close_out();
	end
endmodule : rfa_regs_bench
bind rfa_regs rfa_regs_checker chk_u (
	.clk_i             (clk_i),
	.reset_i           (reset_i),
	.host_addr_i       (host_addr_i),
	.host_rd_i         (host_rd_i),
	.host_wr_i         (host_wr_i),
	.host_rdata_o      (host_rdata_o),
	.frame_done_i      (frame_done_i),
	.frame_len_i       (frame_len_i),
	.frame_crc_bad_i   (frame_crc_bad_i),
	.frame_store_o     (frame_store_o),
	.frame_store_len_o (frame_store_len_o),
	.irq_o             (irq_o),
	.receive_config_o  (receive_config_o),
	.receive_control_o (receive_control_o)
);
